// *** bench/ptpu_load.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// load on the pulse pins: times low pulses on pin 0
// ****************************************************************
module ptpu_load (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  output logic [31:0] low_width,
  output logic [7:0] n_pulses
);
  logic [31:0] run_ff;

  // count only while driven, so the idle low before enabling is ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_ff <= 32'h0;
      low_width <= 32'h0;
      n_pulses <= 8'h00;
    end else if (pin_oe[0] && !pin_o[0]) begin
      run_ff <= run_ff + 32'h1;
    end else if (run_ff != 32'h0) begin
      low_width <= run_ff;
      n_pulses <= n_pulses + 8'h01;
      run_ff <= 32'h0;
    end
  end
endmodule : ptpu_load

`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// register-level test of the pwm and pulse unit
// ****************************************************************
module tb_top;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, c, low_width;
  logic [7:0] out_a, out_b, pin_o, pin_oe, n_pulses, np0;
  int fails = 0;
  int tests_run = 0;

  ptpu_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_output_first(out_a), .channel_output_second(out_b), .pulse_pin_o(pin_o), .pulse_pin_oe(pin_oe));
  ptpu_load load_u (.sys_clk(sys_clk), .rst_n(rst_n), .pin_o(pin_o), .pin_oe(pin_oe),
    .low_width(low_width), .n_pulses(n_pulses));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; the request is held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      fails++;
      tally_and_finish();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd);
  endtask : wr

  // high cycles of one output over n cycles, sampled where settled
  task automatic count_hi(input bit sel_b, input int ch, input int n, output logic [31:0] cnt);
    cnt = 32'h0;
    repeat (n) begin
      @(negedge sys_clk);
      cnt = cnt + 32'(sel_b ? out_b[ch] : out_a[ch]);
    end
  endtask : count_hi

  // hang guard
  initial begin
    #2_000_000;
    fails++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values and refused addresses
    apb(1'b0, 12'h00c, 32'h0, rd);
    check(rd, 32'h0);
    apb(1'b0, 12'h1f0, 32'h0, rd);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h002, 32'h0, rd);
    check({31'h0, err}, 32'h1);
    // channel 0: both outputs on one counter, one inverted
    wr(12'h000, 32'h9);
    wr(12'h004, 32'd500);
    wr(12'h008, 32'h6d4); // minus 300 tenths
    wr(12'h00c, 32'h3);
    count_hi(1'b0, 0, 10, c);
    check(c, 32'd10 * 500 / 1000);
    count_hi(1'b1, 0, 10, c);
    check(c, 32'd10 - 32'd10 * 300 / 1000);
    // channel 1 deferred: idle until sync
    wr(12'h010, 32'h9);
    wr(12'h014, 32'd1000);
    wr(12'h01c, 32'h9);
    count_hi(1'b0, 1, 20, c);
    check(c, 32'h0);
    apb(1'b0, 12'h01c, 32'h0, rd);
    check(rd & 32'h10, 32'h0);
    wr(12'h100, 32'h0);
    @(posedge sys_clk); // outputs lag the run bit by one clock
    count_hi(1'b0, 1, 10, c);
    check(c, 32'd10);
    count_hi(1'b0, 0, 10, c);
    check(c, 32'd5);
    // channel 2 centre-aligned: count 0..9..0 over 18 clocks
    wr(12'h020, 32'h9);
    wr(12'h024, 32'd500);
    wr(12'h02c, 32'h5);
    @(posedge sys_clk); // outputs lag the run bit by one clock
    count_hi(1'b0, 2, 18, c);
    check(c, 32'd9);
    apb(1'b0, 12'h114, 32'h0, rd);
    check(rd & 32'hff, 32'h7);
    // servo setup on channels 3 and 4
    wr(12'h110, 32'h364);
    wr(12'h110, 32'h401);
    apb(1'b0, 12'h030, 32'h0, rd);
    check(rd, 32'(40_000_000 / 50 - 1));
    apb(1'b0, 12'h034, 32'h0, rd);
    check(rd & 32'h7ff, 32'd50 + 32'd50);
    apb(1'b0, 12'h044, 32'h0, rd);
    check(rd & 32'h7ff, 32'd51);
    // short pulse on pin 0, pins driven high first
    wr(12'h108, 32'h3);
    wr(12'h10c, 32'h3);
    np0 = n_pulses;
    wr(12'h104, 32'ha);
    for (int i = 0; i < 1000 && n_pulses === np0; i++) @(posedge sys_clk);
    check({24'h0, n_pulses}, {24'h0, np0 + 8'h01});
    check(low_width, 32'd10 * 40);
    check({24'h0, pin_oe}, 32'h3);
    // long pulse on pin 1, then ended by zero width
    wr(12'h104, 32'h01000bb8);
    @(negedge sys_clk);
    check({31'h0, pin_o[1]}, 32'h0);
    apb(1'b0, 12'h114, 32'h0, rd);
    check((rd >> 8) & 32'hff, 32'h2);
    wr(12'h104, 32'h01000000);
    @(negedge sys_clk);
    check({31'h0, pin_o[1]}, 32'h1);
    // a period below the floor is raised to four clocks
    wr(12'h050, 32'h1);
    apb(1'b0, 12'h050, 32'h0, rd);
    check(rd, 32'(ptpu_pkg::MIN_TOP));
    // five long pulses fill the slots; the sixth is dropped and flagged
    for (int p = 2; p < 8; p++) wr(12'h104, (32'(p) << 24) | 32'h00000bb8);
    apb(1'b0, 12'h114, 32'h0, rd);
    check((rd >> 8) & 32'h1ff, 32'h17c);
    check({24'h0, pin_o}, 32'h7f);
    wr(12'h114, 32'h00010000);
    apb(1'b0, 12'h114, 32'h0, rd);
    check((rd >> 8) & 32'h1ff, 32'h07c);
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire

// *** rtl/ptpu_chan.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// one channel: shared counter, two compare outputs
// ****************************************************************
module ptpu_chan (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [23:0] top,
  input wire logic signed [10:0] first_output_duty,
  input wire logic signed [10:0] second_output_duty,
  input wire logic en_a,
  input wire logic en_b,
  input wire logic phase,
  input wire logic run,
  input wire logic sync,
  output logic channel_output_first,
  output logic channel_output_second
);

  logic [23:0] cnt_ff, nxt_cnt;
  logic down_ff, nxt_down;
  logic out_a_ff, nxt_out_a;
  logic out_b_ff, nxt_out_b;
  logic [24:0] thr_a, thr_b;

  // shorter periods leave fewer steps, so fewer duty settings
  assign thr_a = ptpu_pkg::ptpu_duty_count(top, first_output_duty);
  assign thr_b = ptpu_pkg::ptpu_duty_count(top, second_output_duty);

  // counter: sawtooth or triangle, restarted by sync
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_down = down_ff;
    if (!run || sync) begin
      nxt_cnt = 24'h000000;
      nxt_down = 1'b0;
    end else if (phase) begin
      if (!down_ff) begin
        if (cnt_ff >= top) begin
          nxt_down = 1'b1;
          nxt_cnt = cnt_ff - 24'h000001;
        end else begin
          nxt_cnt = cnt_ff + 24'h000001;
        end
      end else if (cnt_ff == 24'h000000) begin
        nxt_down = 1'b0;
        nxt_cnt = 24'h000001;
      end else begin
        nxt_cnt = cnt_ff - 24'h000001;
      end
    end else begin
      nxt_cnt = (cnt_ff >= top) ? 24'h000000 : cnt_ff + 24'h000001;
    end
    // both outputs read the one counter; negative duty inverts
    nxt_out_a = run && en_a && (({1'b0, cnt_ff} < thr_a) ^ first_output_duty[10]);
    nxt_out_b = run && en_b && (({1'b0, cnt_ff} < thr_b) ^ second_output_duty[10]);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 24'h000000;
      down_ff <= 1'b0;
      out_a_ff <= 1'b0;
      out_b_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      down_ff <= nxt_down;
      out_a_ff <= nxt_out_a;
      out_b_ff <= nxt_out_b;
    end
  end

  assign channel_output_first = out_a_ff;
  assign channel_output_second = out_b_ff;

endmodule : ptpu_chan

`default_nettype wire

// *** rtl/ptpu_pkg.sv ***
package ptpu_pkg;

  // ****************************************************************
  // sizes and timing
  // ****************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int NUM_CH = 8;
  localparam int NUM_PIN = 8;
  localparam int NUM_SLOT = 5;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam logic [5:0] US_TICK_LAST = 6'(CYC_PER_US - 1);
  localparam int SHORT_LIMIT_MS = 3;
  localparam logic [23:0] SHORT_LIMIT_US = 24'(SHORT_LIMIT_MS * 1000);
  localparam logic [23:0] MIN_TOP = 24'h000003; // four clocks per period at most speed
  localparam logic [9:0] DUTY_FULL = 10'h3e8; // 100.0 percent in tenths
  localparam logic [34:0] DUTY_HALF = 35'h00000001f4;
  localparam logic [34:0] DUTY_DIV = 35'h00000003e8;
  localparam int SERVO_HZ = 50;
  localparam logic [23:0] SERVO_TOP = 24'(CLK_HZ / SERVO_HZ - 1);
  localparam logic [10:0] SERVO_BASE = 11'h032; // 5.0 percent in tenths
  localparam logic [6:0] SERVO_POS_MAX = 7'h64;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] ADDR_CH_REGION = 4'h0;
  localparam logic [11:0] ADDR_GLB_BASE = 12'h100;
  localparam logic [1:0] REG_PERIOD = 2'h0;
  localparam logic [1:0] REG_DUTY_A = 2'h1;
  localparam logic [1:0] REG_DUTY_B = 2'h2;
  localparam logic [1:0] REG_CTRL = 2'h3;
  localparam logic [2:0] GLB_SYNC = 3'h0;
  localparam logic [2:0] GLB_PULSE = 3'h1;
  localparam logic [2:0] GLB_LEVEL = 3'h2;
  localparam logic [2:0] GLB_OE = 3'h3;
  localparam logic [2:0] GLB_SERVO = 3'h4;
  localparam logic [2:0] GLB_STATUS = 3'h5;
  localparam int CTRL_EN_A = 0;
  localparam int CTRL_EN_B = 1;
  localparam int CTRL_PHASE = 2;
  localparam int CTRL_DEFER = 3;
  localparam int CTRL_RUN = 4;
  localparam int PULSE_PIN_LSB = 24;
  localparam int SERVO_CH_LSB = 8;
  localparam int STATUS_ACT_LSB = 8;
  localparam int STATUS_OVF = 16;

  // signed tenths of a percent to a whole count step, rounded to nearest
  function automatic logic [24:0] ptpu_duty_count(input logic [23:0] top, input logic signed [10:0] duty);
    logic [10:0] mag;
    logic [34:0] prod;
    logic [34:0] q;
    // eleven bits, so the most negative code keeps its magnitude and clamps
    mag = duty[10] ? 11'(-duty) : 11'(duty);
    if (mag > {1'b0, DUTY_FULL}) begin
      mag = {1'b0, DUTY_FULL};
    end
    prod = ({11'h000, top} + 35'h1) * {24'h000000, mag};
    q = (prod + DUTY_HALF) / DUTY_DIV;
    return q[24:0];
  endfunction : ptpu_duty_count

endpackage : ptpu_pkg

// *** rtl/ptpu_top.sv ***
// Contract
// - eight channels, sixteen individually set outputs
// - either or both outputs per channel
// - signed duty, negative inverts the output
// - period counter reaches two to twenty-four
// - fastest period is four core clocks
// - fewer duty steps at high frequency
// - phase bit selects centre-aligned counting
// - deferred channel loads but stays idle
// - sync starts deferred, realigns running channels
// - servo: 50 Hz, 5 percent plus position
// - pulse drives pin opposite, then restores
// - pulse width given with microsecond resolution
// - short pulses exact to one microsecond
// - long pulses within half a millisecond
// - five long pulses run in background
// - new request replaces except a long one at its slot's last tick, zero width ends
`timescale 1ns/1ps
`default_nettype none

module ptpu_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] channel_output_first,
  output logic [7:0] channel_output_second,
  output logic [7:0] pulse_pin_o,
  output logic [7:0] pulse_pin_oe
);

  // ****************************************************************
  // apb slave and channel registers
  // ****************************************************************
  logic [23:0] period_ff [ptpu_pkg::NUM_CH];
  logic [23:0] nxt_period [ptpu_pkg::NUM_CH];
  logic [10:0] duty_a_ff [ptpu_pkg::NUM_CH];
  logic [10:0] nxt_duty_a [ptpu_pkg::NUM_CH];
  logic [10:0] duty_b_ff [ptpu_pkg::NUM_CH];
  logic [10:0] nxt_duty_b [ptpu_pkg::NUM_CH];
  logic [3:0] ctrl_ff [ptpu_pkg::NUM_CH];
  logic [3:0] nxt_ctrl [ptpu_pkg::NUM_CH];
  logic [7:0] run_ff, nxt_run;
  logic [7:0] sync_ff, nxt_sync;
  logic [7:0] level_ff, nxt_level;
  logic [7:0] oe_ff, nxt_oe;
  logic ovf_ff, nxt_ovf;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic is_ch, is_glb, hit, wr_en;
  logic [2:0] ch_idx, glb_idx;
  logic [1:0] reg_idx;
  logic [7:0] pin_act;
  logic [4:0] slot_busy;
  logic pulse_req, set_ovf;
  logic [6:0] servo_pos;
  logic [2:0] servo_ch;

  assign is_ch = (paddr[11:8] == ptpu_pkg::ADDR_CH_REGION) && !paddr[7];
  assign is_glb = (paddr[11:5] == ptpu_pkg::ADDR_GLB_BASE[11:5]) && (paddr[4:2] <= ptpu_pkg::GLB_STATUS);
  assign hit = (is_ch || is_glb) && (paddr[1:0] == 2'h0);
  assign ch_idx = paddr[6:4];
  assign reg_idx = paddr[3:2];
  assign glb_idx = paddr[4:2];
  // a write lands only at the edge that completes the access phase
  assign wr_en = psel && penable && pready_ff && pwrite && hit;
  assign pulse_req = wr_en && is_glb && (glb_idx == ptpu_pkg::GLB_PULSE);
  assign servo_pos = (pwdata[6:0] > ptpu_pkg::SERVO_POS_MAX) ? ptpu_pkg::SERVO_POS_MAX : pwdata[6:0];
  assign servo_ch = pwdata[ptpu_pkg::SERVO_CH_LSB +: 3];

  // register updates, read data prepared in the setup cycle
  always_comb begin
    nxt_period = period_ff;
    nxt_duty_a = duty_a_ff;
    nxt_duty_b = duty_b_ff;
    nxt_ctrl = ctrl_ff;
    nxt_run = run_ff;
    nxt_sync = 8'h00;
    nxt_level = level_ff;
    nxt_oe = oe_ff;
    nxt_ovf = ovf_ff;
    nxt_pready = psel && !penable;
    nxt_pslverr = psel && !penable && !hit;
    nxt_prdata = 32'h00000000;
    if (wr_en && is_ch) begin
      unique case (reg_idx)
        ptpu_pkg::REG_PERIOD: begin
          // anything below four clocks is raised to the floor
          nxt_period[ch_idx] = (pwdata[23:0] < ptpu_pkg::MIN_TOP) ? ptpu_pkg::MIN_TOP : pwdata[23:0];
        end
        ptpu_pkg::REG_DUTY_A: nxt_duty_a[ch_idx] = pwdata[10:0];
        ptpu_pkg::REG_DUTY_B: nxt_duty_b[ch_idx] = pwdata[10:0];
        ptpu_pkg::REG_CTRL: begin
          nxt_ctrl[ch_idx] = pwdata[3:0];
          nxt_run[ch_idx] = !pwdata[ptpu_pkg::CTRL_DEFER];
        end
      endcase
    end
    if (wr_en && is_glb) begin
      unique case (glb_idx)
        ptpu_pkg::GLB_SYNC: begin
          for (int i = 0; i < ptpu_pkg::NUM_CH; i++) begin
            if (ctrl_ff[i][ptpu_pkg::CTRL_DEFER]) begin
              nxt_run[i] = 1'b1;
            end
          end
          nxt_sync = run_ff;
        end
        ptpu_pkg::GLB_LEVEL: nxt_level = pwdata[7:0];
        ptpu_pkg::GLB_OE: nxt_oe = pwdata[7:0];
        ptpu_pkg::GLB_SERVO: begin
          nxt_period[servo_ch] = ptpu_pkg::SERVO_TOP;
          nxt_duty_a[servo_ch] = ptpu_pkg::SERVO_BASE + 11'((servo_pos + 7'h01) >> 1);
          nxt_ctrl[servo_ch] = 4'h1;
          nxt_run[servo_ch] = 1'b1;
        end
        ptpu_pkg::GLB_STATUS: begin
          if (pwdata[ptpu_pkg::STATUS_OVF]) begin
            nxt_ovf = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // a lost request in the clearing cycle still sets the flag
    if (set_ovf) begin
      nxt_ovf = 1'b1;
    end
    if (psel && !penable && !pwrite && hit) begin
      if (is_ch) begin
        unique case (reg_idx)
          ptpu_pkg::REG_PERIOD: nxt_prdata = {8'h00, period_ff[ch_idx]};
          ptpu_pkg::REG_DUTY_A: nxt_prdata = {{21{duty_a_ff[ch_idx][10]}}, duty_a_ff[ch_idx]};
          ptpu_pkg::REG_DUTY_B: nxt_prdata = {{21{duty_b_ff[ch_idx][10]}}, duty_b_ff[ch_idx]};
          ptpu_pkg::REG_CTRL: nxt_prdata = {27'h0000000, run_ff[ch_idx], ctrl_ff[ch_idx]};
        endcase
      end else begin
        unique case (glb_idx)
          ptpu_pkg::GLB_PULSE: nxt_prdata = {27'h0000000, slot_busy};
          ptpu_pkg::GLB_LEVEL: nxt_prdata = {24'h000000, level_ff};
          ptpu_pkg::GLB_OE: nxt_prdata = {24'h000000, oe_ff};
          ptpu_pkg::GLB_STATUS: nxt_prdata = {15'h0000, ovf_ff, pin_act, run_ff};
          default: nxt_prdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ptpu_pkg::NUM_CH; i++) begin
        period_ff[i] <= ptpu_pkg::MIN_TOP;
        duty_a_ff[i] <= 11'h000;
        duty_b_ff[i] <= 11'h000;
        ctrl_ff[i] <= 4'h0;
      end
      run_ff <= 8'h00;
      sync_ff <= 8'h00;
      level_ff <= 8'h00;
      oe_ff <= 8'h00;
      ovf_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      period_ff <= nxt_period;
      duty_a_ff <= nxt_duty_a;
      duty_b_ff <= nxt_duty_b;
      ctrl_ff <= nxt_ctrl;
      run_ff <= nxt_run;
      sync_ff <= nxt_sync;
      level_ff <= nxt_level;
      oe_ff <= nxt_oe;
      ovf_ff <= nxt_ovf;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pulse_pin_oe = oe_ff;

  // ****************************************************************
  // channels
  // ****************************************************************
  for (genvar c = 0; c < ptpu_pkg::NUM_CH; c++) begin : g_ch
    ptpu_chan u_chan (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .top(period_ff[c]),
      .first_output_duty(duty_a_ff[c]),
      .second_output_duty(duty_b_ff[c]),
      .en_a(ctrl_ff[c][ptpu_pkg::CTRL_EN_A]),
      .en_b(ctrl_ff[c][ptpu_pkg::CTRL_EN_B]),
      .phase(ctrl_ff[c][ptpu_pkg::CTRL_PHASE]),
      .run(run_ff[c]),
      .sync(sync_ff[c]),
      .channel_output_first(channel_output_first[c]),
      .channel_output_second(channel_output_second[c])
    );
  end

  // ****************************************************************
  // timed pulses: one exact short engine, five background slots
  // ****************************************************************
  logic [5:0] us_cnt_ff, nxt_us_cnt;
  logic short_busy_ff, nxt_short_busy;
  logic [2:0] short_pin_ff, nxt_short_pin;
  logic [16:0] short_cnt_ff, nxt_short_cnt;
  logic [4:0] slot_busy_ff, nxt_slot_busy;
  logic [2:0] slot_pin_ff [ptpu_pkg::NUM_SLOT];
  logic [2:0] nxt_slot_pin [ptpu_pkg::NUM_SLOT];
  logic [23:0] slot_left_ff [ptpu_pkg::NUM_SLOT];
  logic [23:0] nxt_slot_left [ptpu_pkg::NUM_SLOT];
  logic [7:0] pval_ff, nxt_pval;
  logic [7:0] pin_ff, nxt_pin;
  logic [2:0] req_pin;
  logic [23:0] req_us;
  logic us_tick, placed;
  logic [7:0] act_next;

  assign req_pin = pwdata[ptpu_pkg::PULSE_PIN_LSB +: 3];
  assign req_us = pwdata[23:0];
  assign us_tick = (us_cnt_ff == ptpu_pkg::US_TICK_LAST);
  assign slot_busy = slot_busy_ff;

  // which pins are under a pulse now
  always_comb begin
    pin_act = 8'h00;
    if (short_busy_ff) begin
      pin_act[short_pin_ff] = 1'b1;
    end
    for (int s = 0; s < ptpu_pkg::NUM_SLOT; s++) begin
      if (slot_busy_ff[s]) begin
        pin_act[slot_pin_ff[s]] = 1'b1;
      end
    end
  end

  // engine next state; requests override the count-down except the end of a slot on its last tick
  always_comb begin
    nxt_us_cnt = us_tick ? 6'h00 : us_cnt_ff + 6'h01;
    nxt_short_busy = short_busy_ff;
    nxt_short_pin = short_pin_ff;
    nxt_short_cnt = short_cnt_ff;
    nxt_slot_busy = slot_busy_ff;
    nxt_slot_pin = slot_pin_ff;
    nxt_slot_left = slot_left_ff;
    set_ovf = 1'b0;
    placed = 1'b0;
    if (short_busy_ff) begin
      // cycle-exact count keeps short pulses within a microsecond
      if (short_cnt_ff == 17'h00001) begin
        nxt_short_busy = 1'b0;
      end
      nxt_short_cnt = short_cnt_ff - 17'h00001;
    end
    for (int s = 0; s < ptpu_pkg::NUM_SLOT; s++) begin
      if (slot_busy_ff[s] && us_tick) begin
        // microsecond ticks are far inside the half-millisecond budget
        if (slot_left_ff[s] == 24'h000001) begin
          nxt_slot_busy[s] = 1'b0;
        end
        nxt_slot_left[s] = slot_left_ff[s] - 24'h000001;
      end
    end
    if (pulse_req) begin
      // any earlier pulse on this pin gives way to the new request
      if (short_busy_ff && short_pin_ff == req_pin) begin
        nxt_short_busy = 1'b0;
      end
      for (int s = 0; s < ptpu_pkg::NUM_SLOT; s++) begin
        if (slot_busy_ff[s] && slot_pin_ff[s] == req_pin) begin
          if (req_us >= ptpu_pkg::SHORT_LIMIT_US) begin
            nxt_slot_left[s] = req_us;
            placed = 1'b1;
          end else begin
            nxt_slot_busy[s] = 1'b0;
          end
        end
      end
      if (req_us != 24'h000000 && req_us < ptpu_pkg::SHORT_LIMIT_US) begin
        nxt_short_busy = 1'b1;
        nxt_short_pin = req_pin;
        nxt_short_cnt = 17'(req_us * ptpu_pkg::CYC_PER_US);
      end else if (req_us >= ptpu_pkg::SHORT_LIMIT_US && !placed) begin
        for (int s = 0; s < ptpu_pkg::NUM_SLOT; s++) begin
          if (!slot_busy_ff[s] && !placed) begin
            nxt_slot_busy[s] = 1'b1;
            nxt_slot_pin[s] = req_pin;
            nxt_slot_left[s] = req_us;
            placed = 1'b1;
          end
        end
        // all five slots taken: request dropped and flagged
        set_ovf = !placed;
      end
    end
    act_next = 8'h00;
    if (nxt_short_busy) begin
      act_next[nxt_short_pin] = 1'b1;
    end
    for (int s = 0; s < ptpu_pkg::NUM_SLOT; s++) begin
      if (nxt_slot_busy[s]) begin
        act_next[nxt_slot_pin[s]] = 1'b1;
      end
    end
    // polarity is caught when a pin goes from idle to pulsing
    for (int p = 0; p < ptpu_pkg::NUM_PIN; p++) begin
      nxt_pval[p] = pin_act[p] ? pval_ff[p] : !pin_ff[p];
      nxt_pin[p] = act_next[p] ? nxt_pval[p] : nxt_level[p];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      us_cnt_ff <= 6'h00;
      short_busy_ff <= 1'b0;
      short_pin_ff <= 3'h0;
      short_cnt_ff <= 17'h00000;
      slot_busy_ff <= 5'h00;
      for (int s = 0; s < ptpu_pkg::NUM_SLOT; s++) begin
        slot_pin_ff[s] <= 3'h0;
        slot_left_ff[s] <= 24'h000000;
      end
      pval_ff <= 8'h00;
      pin_ff <= 8'h00;
    end else begin
      us_cnt_ff <= nxt_us_cnt;
      short_busy_ff <= nxt_short_busy;
      short_pin_ff <= nxt_short_pin;
      short_cnt_ff <= nxt_short_cnt;
      slot_busy_ff <= nxt_slot_busy;
      slot_pin_ff <= nxt_slot_pin;
      slot_left_ff <= nxt_slot_left;
      pval_ff <= nxt_pval;
      pin_ff <= nxt_pin;
    end
  end

  assign pulse_pin_o = pin_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic per_ok;
  logic [7:0] defer_mask;
  always_comb begin
    per_ok = 1'b1;
    defer_mask = 8'h00;
    for (int i = 0; i < ptpu_pkg::NUM_CH; i++) begin
      defer_mask[i] = ctrl_ff[i][ptpu_pkg::CTRL_DEFER];
      if (period_ff[i] < ptpu_pkg::MIN_TOP) begin
        per_ok = 1'b0;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_setup; psel && !penable; endsequence
  sequence s_ctrl_wr; wr_en && is_ch && reg_idx == ptpu_pkg::REG_CTRL; endsequence

  AST_PERIOD_FLOOR: assert property (per_ok) else $error("period below floor");
  AST_DEFER_IDLE: assert property (s_ctrl_wr ##1 1'b1 |->
    run_ff[$past(ch_idx)] == !$past(pwdata[ptpu_pkg::CTRL_DEFER])) else $error("defer not honoured");
  AST_SYNC_START: assert property (wr_en && is_glb && glb_idx == ptpu_pkg::GLB_SYNC |=>
    (run_ff & $past(defer_mask)) == $past(defer_mask) && sync_ff == $past(run_ff)) else $error("sync missed");
  AST_PULSE_INVERT: assert property (pulse_req && req_us != 24'h000000 && !pin_act[req_pin] && !set_ovf |=>
    pin_ff[$past(req_pin)] == !$past(pin_ff[req_pin])) else $error("pulse polarity wrong");
  AST_SHORT_LOAD: assert property (pulse_req && req_us != 24'h000000 && req_us < ptpu_pkg::SHORT_LIMIT_US |=>
    short_busy_ff && short_cnt_ff == 17'($past(req_us) * ptpu_pkg::CYC_PER_US)) else $error("short count wrong");
  AST_ZERO_ENDS: assert property (pulse_req && req_us == 24'h000000 |=>
    !pin_act[$past(req_pin)]) else $error("zero width did not end pulse");
  AST_LONG_PLACE: assert property (pulse_req && req_us >= ptpu_pkg::SHORT_LIMIT_US && slot_busy_ff != 5'h1f |=>
    pin_act[$past(req_pin)]) else $error("long pulse not placed");
  AST_US_TICK: assert property (us_tick |=> !us_tick [*8]) else $error("tick too frequent");
  AST_APB_ANSWER: assert property (s_setup |=> pready_ff) else $error("no ready in access");

endmodule : ptpu_top

`default_nettype wire
